/* rdc_params.svh */
// Purpose: constants for the reload down counter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: offsets chosen locally, timing from a 25 MHz clock
`ifndef RDC_PARAMS_SVH
`define RDC_PARAMS_SVH

// ************************************************************
// register map
// ************************************************************
`define RDC_ADDR_CTRL 12'h000
`define RDC_ADDR_COUNT 12'h004
`define RDC_ADDR_W 12

// ************************************************************
// control field positions
// ************************************************************
`define RDC_B_TRG 0
`define RDC_B_RUN 1
`define RDC_B_UF 2
`define RDC_B_IRQE 3
`define RDC_B_AUTOLOAD_SELECT 4
`define RDC_B_POL 5
`define RDC_B_WAVE_PIN_ENABLE 6
`define RDC_B_TRIGGER_CFG_LOW 7
`define RDC_B_TRIGGER_CFG_MID 8
`define RDC_B_TRIGGER_CFG_TOP 9
`define RDC_B_CSL_LO 10
`define RDC_B_CSL_HI 11
`define RDC_CSL_EVENT 2'h3
`define RDC_CTRL_RST 12'h000
`define RDC_COUNT_RST 16'h0000
`define RDC_COUNT_ZERO 16'h0000
`define RDC_COUNT_ONE 16'h0001

// ************************************************************
// count clock divider end counts, one tick every value plus one machine cycles
// ************************************************************
`define RDC_DIV_SEL0 5'h01
`define RDC_DIV_SEL1 5'h07
`define RDC_DIV_SEL2 5'h1f
`define RDC_DIV_ZERO 5'h00
`define RDC_DIV_ONE 5'h01

`endif

/* rdc_pkg.sv */
// Purpose: types for the reload down counter
// Assumes: included params header for numbers
// Notes: holds the run state type only
package rdc_pkg;
  typedef enum logic [1:0] {
    RDC_STOP,
    RDC_WAIT,
    RDC_LOAD,
    RDC_RUN
  } rdc_state_t;
endpackage : rdc_pkg

/* rdc_reload_counter.sv */
// Purpose: 16-bit reload down counter with trigger, gate and event modes, APB slave
// Assumes: input pin sampled on CLK, APB master, no wait states
// Notes: one channel; wave pin mux to port logic is left outside
// Notes: count and reload come up at zero after reset, software must load first
// Notes: a read-modify-write view of the flag does not exist on APB
`timescale 1ns/1ps
`include "rdc_params.svh"

module rdc_reload_counter (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EVENT_INPUT_PIN,
  output logic WAVE_PIN,
  output logic WAVE_PIN_ENABLE,
  output logic IRQ
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [11:0] ctrl_reg;
  logic uf_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [4:0] div_reg;
  logic wave_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  rdc_pkg::rdc_state_t state_reg;

  // ************************************************************
  // decode
  // ************************************************************
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_count;
  logic run_en;
  logic event_mode;
  logic gate_mode;
  logic rise;
  logic fall;
  logic edge_hit;
  logic soft_trig;
  logic pin_trig;
  logic count_tick;
  logic underflow;
  logic div_done;
  logic [4:0] div_limit;

  function automatic logic edge_sel(input logic [1:0] sel, input logic r, input logic f);
    edge_sel = (sel[0] & r) | (sel[1] & f);
  endfunction : edge_sel

  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & ~PWRITE;
  assign hit_ctrl = (PADDR == `RDC_ADDR_CTRL);
  assign hit_count = (PADDR == `RDC_ADDR_COUNT);
  assign run_en = ctrl_reg[`RDC_B_RUN];
  assign event_mode = (ctrl_reg[`RDC_B_CSL_HI:`RDC_B_CSL_LO] == `RDC_CSL_EVENT);
  assign gate_mode = ~event_mode & ctrl_reg[`RDC_B_TRIGGER_CFG_TOP];
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign edge_hit = edge_sel(ctrl_reg[`RDC_B_TRIGGER_CFG_MID:`RDC_B_TRIGGER_CFG_LOW], rise, fall);
  assign soft_trig = wr & hit_ctrl & PWDATA[`RDC_B_TRG] & PWDATA[`RDC_B_RUN] & run_en;
  assign pin_trig = ~event_mode & ~ctrl_reg[`RDC_B_TRIGGER_CFG_TOP] & edge_hit;

  always_comb begin
    unique case (ctrl_reg[`RDC_B_CSL_HI:`RDC_B_CSL_LO])
      2'h0: div_limit = `RDC_DIV_SEL0;
      2'h1: div_limit = `RDC_DIV_SEL1;
      2'h2: div_limit = `RDC_DIV_SEL2;
      default: div_limit = `RDC_DIV_ZERO;
    endcase
  end

  assign div_done = (div_reg == div_limit);
  // gate mode checks the chosen level on every tick
  always_comb begin
    if (event_mode) begin
      count_tick = edge_hit;
    end else if (gate_mode) begin
      count_tick = div_done & (sync2_reg == ctrl_reg[`RDC_B_TRIGGER_CFG_LOW]);
    end else begin
      count_tick = div_done;
    end
  end
  assign underflow = (state_reg == rdc_pkg::RDC_RUN) & count_tick
                     & (count_reg == `RDC_COUNT_ZERO);

  // ************************************************************
  // input synchroniser
  // ************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= EVENT_INPUT_PIN;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= `RDC_CTRL_RST;
    end else if (wr & hit_ctrl) begin
      ctrl_reg <= PWDATA[11:0];
      ctrl_reg[`RDC_B_TRG] <= 1'b0;
      ctrl_reg[`RDC_B_UF] <= 1'b0;
    end
  end

  // set wins over a clearing write in the same cycle
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      uf_reg <= 1'b0;
    end else if (underflow) begin
      uf_reg <= 1'b1;
    end else if (wr & hit_ctrl & ~PWDATA[`RDC_B_UF]) begin
      uf_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      reload_reg <= `RDC_COUNT_RST;
    end else if (wr & hit_count) begin
      reload_reg <= PWDATA[15:0];
    end
  end

  // ************************************************************
  // run state
  // ************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= rdc_pkg::RDC_STOP;
    end else if (wr & hit_ctrl & ~PWDATA[`RDC_B_RUN]) begin
      state_reg <= rdc_pkg::RDC_STOP;
    end else if (soft_trig) begin
      state_reg <= rdc_pkg::RDC_LOAD;
    end else begin
      unique case (state_reg)
        rdc_pkg::RDC_STOP: begin
          if (wr & hit_ctrl & PWDATA[`RDC_B_RUN]) begin
            state_reg <= rdc_pkg::RDC_WAIT;
          end
        end
        rdc_pkg::RDC_WAIT: begin
          if (pin_trig) begin
            state_reg <= rdc_pkg::RDC_LOAD;
          end
        end
        rdc_pkg::RDC_LOAD: state_reg <= rdc_pkg::RDC_RUN;
        rdc_pkg::RDC_RUN: begin
          if (pin_trig) begin
            state_reg <= rdc_pkg::RDC_LOAD;
          end else if (underflow & ~ctrl_reg[`RDC_B_AUTOLOAD_SELECT]) begin
            state_reg <= rdc_pkg::RDC_WAIT;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // prescaler and counter
  // ************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_reg <= `RDC_DIV_ZERO;
    end else if (state_reg != rdc_pkg::RDC_RUN || div_done) begin
      div_reg <= `RDC_DIV_ZERO;
    end else begin
      div_reg <= div_reg + `RDC_DIV_ONE;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      count_reg <= `RDC_COUNT_RST;
    end else if (state_reg == rdc_pkg::RDC_LOAD) begin
      count_reg <= reload_reg;
    end else if (state_reg == rdc_pkg::RDC_RUN && count_tick) begin // holds otherwise
      if (underflow && ctrl_reg[`RDC_B_AUTOLOAD_SELECT]) begin
        count_reg <= reload_reg;
      end else begin
        count_reg <= count_reg - `RDC_COUNT_ONE;
      end
    end
  end

  // ************************************************************
  // wave output
  // ************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wave_reg <= 1'b0;
    end else if (state_reg == rdc_pkg::RDC_LOAD) begin
      wave_reg <= ctrl_reg[`RDC_B_AUTOLOAD_SELECT] ? ctrl_reg[`RDC_B_POL]
                                        : ~ctrl_reg[`RDC_B_POL];
    end else if (underflow) begin
      wave_reg <= ctrl_reg[`RDC_B_AUTOLOAD_SELECT] ? ~wave_reg : ctrl_reg[`RDC_B_POL];
    end else if (state_reg != rdc_pkg::RDC_RUN && !ctrl_reg[`RDC_B_AUTOLOAD_SELECT]) begin
      wave_reg <= ctrl_reg[`RDC_B_POL];
    end
  end

  assign WAVE_PIN = wave_reg;
  assign WAVE_PIN_ENABLE = ctrl_reg[`RDC_B_WAVE_PIN_ENABLE];
  assign IRQ = uf_reg & ctrl_reg[`RDC_B_IRQE];

  // ************************************************************
  // apb read side
  // ************************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd & ~PENABLE) begin
      if (hit_ctrl) begin
        PRDATA <= {20'h00000, ctrl_reg[11:3], uf_reg, ctrl_reg[`RDC_B_RUN], 1'b0};
      end else if (hit_count) begin
        PRDATA <= {16'h0000, count_reg};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_ctrl & ~hit_count;

  // ************************************************************
  // checks
  // ************************************************************
  a_irq_follows_flag: assert property (@(posedge CLK) disable iff (RESET)
    IRQ == (uf_reg & ctrl_reg[`RDC_B_IRQE])) else $error("irq mismatch");
  a_uf_sets: assert property (@(posedge CLK) disable iff (RESET)
    underflow |=> uf_reg) else $error("flag not set");
  a_uf_wrap: assert property (@(posedge CLK) disable iff (RESET)
    underflow |=> count_reg == 16'hffff || ctrl_reg[`RDC_B_AUTOLOAD_SELECT])
    else $error("no wrap");
  a_load_next: assert property (@(posedge CLK) disable iff (RESET)
    state_reg == rdc_pkg::RDC_LOAD |=> count_reg == $past(reload_reg))
    else $error("load missed");
  a_hold_stop: assert property (@(posedge CLK) disable iff (RESET)
    state_reg == rdc_pkg::RDC_STOP |=> $stable(count_reg))
    else $error("count moved");
  a_oneshot_stop: assert property (@(posedge CLK) disable iff (RESET)
    underflow & ~ctrl_reg[`RDC_B_AUTOLOAD_SELECT] & ~soft_trig & ~pin_trig & ~wr
    |=> state_reg == rdc_pkg::RDC_WAIT) else $error("no stop");
  a_soft_start: assert property (@(posedge CLK) disable iff (RESET)
    soft_trig |=> state_reg == rdc_pkg::RDC_LOAD ##1 state_reg == rdc_pkg::RDC_RUN)
    else $error("no start");
  a_toggle_wave: assert property (@(posedge CLK) disable iff (RESET)
    underflow & ctrl_reg[`RDC_B_AUTOLOAD_SELECT] |=> wave_reg != $past(wave_reg))
    else $error("no toggle");
  a_div_period: assert property (@(posedge CLK) disable iff (RESET)
    state_reg == rdc_pkg::RDC_RUN && ctrl_reg[11:10] == 2'h1 && div_reg == 5'h00
    |-> !div_done) else $error("period short");

  // ************************************************************
  // flag and register access checks
  // ************************************************************
  // a clear in the cycle of an underflow loses, so it is left out here
  a_flag_clear: assert property (@(posedge CLK) disable iff (RESET)
    wr & hit_ctrl & ~PWDATA[`RDC_B_UF] & ~underflow
    |=> !uf_reg)
    else $error("flag not cleared");
  a_flag_keep: assert property (@(posedge CLK) disable iff (RESET)
    wr & hit_ctrl & PWDATA[`RDC_B_UF] & uf_reg
    |=> uf_reg)
    else $error("flag lost on write of one");
  a_upper_zero: assert property (@(posedge CLK) disable iff (RESET)
    rd & ~PENABLE & hit_ctrl
    |=> PRDATA[31:12] == 20'h00000)
    else $error("upper control bits not zero");
  // the reload register takes the low half of the bus word only
  a_reload_write: assert property (@(posedge CLK) disable iff (RESET)
    wr & hit_count
    |=> {16'h0000, reload_reg} == ($past(PWDATA) & 32'h0000_ffff))
    else $error("reload write missed");

  // ************************************************************
  // run state checks
  // ************************************************************
  a_stop_on_clear: assert property (@(posedge CLK) disable iff (RESET)
    wr & hit_ctrl & ~PWDATA[`RDC_B_RUN]
    |=> state_reg == rdc_pkg::RDC_STOP)
    else $error("run clear did not stop");
  a_run_wait: assert property (@(posedge CLK) disable iff (RESET)
    wr & hit_ctrl & PWDATA[`RDC_B_RUN] & (state_reg == rdc_pkg::RDC_STOP)
    |=> state_reg == rdc_pkg::RDC_WAIT)
    else $error("run set did not wait");
  // a trigger written before the run bit is set must be dropped
  a_soft_ignored: assert property (@(posedge CLK) disable iff (RESET)
    wr & hit_ctrl & PWDATA[`RDC_B_TRG] & ~run_en & (state_reg == rdc_pkg::RDC_STOP)
    |=> state_reg != rdc_pkg::RDC_LOAD)
    else $error("trigger taken while stopped");
  a_pin_start: assert property (@(posedge CLK) disable iff (RESET)
    pin_trig & (state_reg == rdc_pkg::RDC_WAIT) & ~wr
    |=> state_reg == rdc_pkg::RDC_LOAD)
    else $error("pin trigger missed");
  a_trig_inhibit: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == rdc_pkg::RDC_WAIT) & ~event_mode & ~gate_mode & ~wr
    & (ctrl_reg[`RDC_B_TRIGGER_CFG_MID:`RDC_B_TRIGGER_CFG_LOW] == 2'h0)
    |=> state_reg == rdc_pkg::RDC_WAIT)
    else $error("inhibited trigger started");
  a_wait_hold: assert property (@(posedge CLK) disable iff (RESET)
    state_reg == rdc_pkg::RDC_WAIT
    |=> $stable(count_reg))
    else $error("count moved while waiting");

  // ************************************************************
  // counting and wave checks
  // ************************************************************
  // gate at the wrong level must freeze the count even with ticks due
  a_gate_block: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == rdc_pkg::RDC_RUN) & gate_mode & (sync2_reg != ctrl_reg[`RDC_B_TRIGGER_CFG_LOW])
    |=> $stable(count_reg))
    else $error("count moved outside gate");
  a_event_hold: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == rdc_pkg::RDC_RUN) & event_mode & ~edge_hit
    |=> $stable(count_reg))
    else $error("count moved without event");
  a_reload_refill: assert property (@(posedge CLK) disable iff (RESET)
    underflow & ctrl_reg[`RDC_B_AUTOLOAD_SELECT]
    |=> count_reg == $past(reload_reg))
    else $error("no refill at underflow");
  a_reload_level: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == rdc_pkg::RDC_LOAD) & ctrl_reg[`RDC_B_AUTOLOAD_SELECT] & ~wr
    |=> wave_reg == ctrl_reg[`RDC_B_POL])
    else $error("reload start level wrong");
  a_oneshot_level: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == rdc_pkg::RDC_LOAD) & ~ctrl_reg[`RDC_B_AUTOLOAD_SELECT] & ~wr
    |=> wave_reg == ~ctrl_reg[`RDC_B_POL])
    else $error("one-shot level wrong");

  c_underflow: cover property (@(posedge CLK) underflow);
  c_reload_uf: cover property (@(posedge CLK) underflow & ctrl_reg[`RDC_B_AUTOLOAD_SELECT]);
  c_pin_trig: cover property (@(posedge CLK) pin_trig & (state_reg == rdc_pkg::RDC_WAIT));
  c_event: cover property (@(posedge CLK) event_mode & count_tick);
  c_gate: cover property (@(posedge CLK) gate_mode & count_tick);

endmodule : rdc_reload_counter

/* rdc_pin_source.sv */
// Purpose: far-side source of the trigger, gate and event input pin
// Assumes: the bench asks for a level just after a rising edge
// Notes: each level is held at least MIN_GAP cycles
`timescale 1ns/1ps
module rdc_pin_source #(
  parameter int MIN_GAP = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic want_level,
  output logic pin_level
);
  int gap_cnt;
  // ********
  // edge spacing
  // ********
  // edges closer than the gap would be lost by the counter, so a request waits
  // the pin is only ever driven towards the counter, an input on its side
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_level <= 1'b0;
      gap_cnt <= 0;
    end else if (want_level != pin_level && gap_cnt >= MIN_GAP) begin
      pin_level <= want_level;
      gap_cnt <= 0;
    end else if (gap_cnt < MIN_GAP) begin
      gap_cnt <= gap_cnt + 1;
    end
  end
endmodule : rdc_pin_source

/* reload_down_counter_test.sv */
// Purpose: self-checking bench for the reload down counter
// Assumes: zero-wait APB slave, 25 MHz clock
// Notes: expected counts come from a small integer model
`timescale 1ns/1ps
`include "rdc_params.svh"
module reload_down_counter_test;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, want = 1'b0, err;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd, ctl;
  logic PREADY, PSLVERR, pin, WAVE_PIN, WAVE_PIN_ENABLE, IRQ;
  int fail_count = 0, total_checks = 0, rel, exp_c, uf_n, k, m;
  always #20 CLK = ~CLK;
  rdc_reload_counter dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EVENT_INPUT_PIN(pin), .WAVE_PIN(WAVE_PIN),
    .WAVE_PIN_ENABLE(WAVE_PIN_ENABLE), .IRQ(IRQ));
  rdc_pin_source #(.MIN_GAP(8)) far (.clk(CLK), .reset(RESET), .want_level(want),
    .pin_level(pin));
  // ********
  // shared tasks
  // ********
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // waits one edge first so back-to-back calls never reassign psel in one step
  // every transfer is one whole word, never split into bytes
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task rdx(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdx
  task wait_irq(input int lim);
    k = 0;
    while (IRQ !== 1'b1 && k < lim) begin
      @(posedge CLK);
      k++;
    end
  endtask : wait_irq
  task pulse();
    want <= 1'b1;
    repeat (12) @(posedge CLK);
    want <= 1'b0;
    repeat (12) @(posedge CLK);
  endtask : pulse
  task results();
    $display("fail_count=%0d total_checks=%0d", fail_count, total_checks);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // ********
  // scenarios
  // ********
  initial begin
    k = $urandom(32'h4edb);
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    rdx(`RDC_ADDR_CTRL, 32'h0);
    rel = $urandom_range(60, 20);
    apb(1'b1, `RDC_ADDR_COUNT, rel);
    rdx(`RDC_ADDR_COUNT, 32'h0);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h0041);
    rdx(`RDC_ADDR_COUNT, 32'h0);
    apb(1'b1, `RDC_ADDR_CTRL, 32'hf04a);
    rdx(`RDC_ADDR_CTRL, 32'h004a);
    rdx(`RDC_ADDR_COUNT, 32'h0);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h004b);
    rdx(`RDC_ADDR_CTRL, 32'h004a);
    chk(WAVE_PIN, 1'b1);
    chk(WAVE_PIN_ENABLE, 1'b1);
    apb(1'b0, `RDC_ADDR_COUNT, 32'h0);
    chk(rd < rel, 1'b1);
    wait_irq(300);
    chk(IRQ, 1'b1);
    chk(WAVE_PIN, 1'b0);
    repeat (20) @(posedge CLK);
    rdx(`RDC_ADDR_COUNT, 32'hffff);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h004e);
    rdx(`RDC_ADDR_CTRL, 32'h004e);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h0046);
    @(posedge CLK);
    chk(IRQ, 1'b0);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h0042);
    rdx(`RDC_ADDR_CTRL, 32'h0042);
    // external rising trigger in reload mode
    apb(1'b1, `RDC_ADDR_CTRL, 32'h0);
    apb(1'b1, `RDC_ADDR_COUNT, 32'd30);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h00da);
    pulse();
    chk(WAVE_PIN, 1'b0);
    apb(1'b0, `RDC_ADDR_COUNT, 32'h0);
    chk(rd < 30, 1'b1);
    wait_irq(100);
    chk(IRQ, 1'b1);
    repeat (2) @(posedge CLK);
    chk(WAVE_PIN, 1'b1);
    // event counting: rising, falling, both
    for (m = 1; m < 4; m++) begin
      apb(1'b1, `RDC_ADDR_CTRL, 32'h0);
      rel = $urandom_range(3, 1);
      apb(1'b1, `RDC_ADDR_COUNT, rel);
      ctl = 32'h0c52 | (m << 7);
      apb(1'b1, `RDC_ADDR_CTRL, ctl);
      apb(1'b1, `RDC_ADDR_CTRL, ctl | 32'h1);
      exp_c = rel;
      uf_n = 0;
      repeat (3) begin
        pulse();
        repeat ((m == 3) ? 2 : 1) begin
          if (exp_c == 0) begin
            exp_c = rel;
            uf_n++;
          end else exp_c--;
        end
        rdx(`RDC_ADDR_COUNT, exp_c);
      end
      chk(WAVE_PIN, uf_n % 2);
      rdx(`RDC_ADDR_CTRL, ctl | ((uf_n > 0) << 2));
    end
    // gate mode: count only while the pin is high
    apb(1'b1, `RDC_ADDR_CTRL, 32'h0);
    apb(1'b1, `RDC_ADDR_COUNT, 32'd5);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h0282);
    apb(1'b1, `RDC_ADDR_CTRL, 32'h0283);
    repeat (20) @(posedge CLK);
    rdx(`RDC_ADDR_COUNT, 32'd5);
    want <= 1'b1;
    repeat (30) @(posedge CLK);
    rdx(`RDC_ADDR_COUNT, 32'hffff);
    rdx(`RDC_ADDR_CTRL, 32'h0286);
    want <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    results();
  end
  initial begin
    #(40 * 20000);
    fail_count++;
    results();
  end
endmodule : reload_down_counter_test
